// ---- rtl/qsc_channel.sv ----
// One asynchronous serial channel: register port, baud divider, transmitter, receiver
`timescale 1ns/1ns
module qsc_channel #(
	parameter int FIFO_DEPTH = qsc_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Classic Wishbone slave, 8-bit, word index on register_select_i
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic channel_select_n_i,
	input wire logic [2:0] register_select_i,
	input wire logic [7:0] host_data_bus_i,
	output logic [7:0] host_data_bus_o,
	output logic host_data_bus_oe_o,
	output logic wb_ack_o,
	// Serial line and modem
	input wire logic sin_i,
	input wire logic cts_n_i,
	output logic sout_o,
	output logic rts_n_o,
	output logic dtr_n_o,
	// Interrupt and DMA requests
	output logic channel_interrupt_out_o,
	output qsc_pkg::qsc_dma_s dma_o
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	typedef struct packed {
		logic ack;
		logic oe;
		logic [7:0] rdata;
		logic [3:0] ien;
		logic [7:0] lctl;
		logic [5:0] mctl;
		logic [7:0] scratch;
		logic [15:0] div;
		logic fifo_en;
		logic dma_mode;
		logic [1:0] trig;
		logic [15:0] bcnt;
		logic cts_m;
		logic cts_s;
		logic cts_p;
		logic dcts;
		logic [3:0] err;
		logic thre_pend;
		qsc_pkg::qsc_tx_e txs;
		logic [7:0] tx_sh;
		logic [3:0] tx_bit;
		logic [5:0] tx_tk;
		logic tx_par;
		qsc_pkg::qsc_rx_e rxs;
		logic [7:0] rx_sh;
		logic [3:0] rx_bit;
		logic [3:0] rx_tk;
		logic rx_par;
		logic rx_pe;
		logic rx_one;
	} qsc_state_s;

	qsc_state_s s_q;
	qsc_state_s s_d;

	// Bus and control decode
	logic req;
	logic acc;
	logic dlab;
	logic loop;
	logic pen;
	logic auto_flow;
	logic [3:0] nbits;
	logic [5:0] stop_ticks;
	logic tick;
	// Fifo handshakes
	logic tx_push;
	logic tx_pop;
	logic tx_valid;
	logic tx_ready;
	logic [7:0] tx_head;
	logic [CW-1:0] tx_cnt;
	logic tx_clr;
	logic rx_push;
	logic rx_pop;
	logic rx_valid;
	logic rx_ready;
	logic rx_clr;
	logic [CW-1:0] rx_cnt;
	qsc_pkg::qsc_rx_entry_s rx_new;
	qsc_pkg::qsc_rx_entry_s rx_head;
	// Line and status
	logic tx_line;
	logic tx_wire;
	logic rin;
	logic tx_last;
	logic rx_last;
	logic rx_at_trig;
	logic tx_empty;
	logic temt;
	logic rx_err_head;
	logic [3:0] iid;
	logic tx_go;
	logic tx_load;

	// Decode of the access and the line format
	assign req = wb_cyc_i && wb_stb_i;
	assign acc = req && !s_q.ack && !channel_select_n_i;
	assign dlab = s_q.lctl[qsc_pkg::LC_DLAB];
	assign loop = s_q.mctl[qsc_pkg::MC_LOOP];
	assign pen = s_q.lctl[qsc_pkg::LC_PEN];
	assign auto_flow = s_q.mctl[qsc_pkg::MC_AFE] && s_q.fifo_en;
	assign nbits = {2'b00, s_q.lctl[qsc_pkg::LC_WLEN +: 2]} + 4'h5;
	assign tx_last = (s_q.tx_bit == nbits) || (s_q.tx_bit == nbits - 4'h1 && !pen);
	assign rx_last = (s_q.rx_bit == nbits) || (s_q.rx_bit == nbits - 4'h1 && !pen);
	assign rx_at_trig = 8'(rx_cnt) >= qsc_pkg::RX_TRIG[s_q.trig];
	assign tx_empty = !tx_valid;
	assign temt = tx_empty && (s_q.txs == qsc_pkg::TX_IDLE);
	assign tx_go = tx_valid && !(auto_flow && !s_q.cts_s);
	assign rx_err_head = s_q.fifo_en && rx_valid && (rx_head.bi || rx_head.fe || rx_head.pe);

	// Stop length in ticks
	always_comb begin
		if (!s_q.lctl[qsc_pkg::LC_STOP]) begin
			stop_ticks = qsc_pkg::STOP_1;
		end else if (s_q.lctl[qsc_pkg::LC_WLEN +: 2] == 2'b00) begin
			stop_ticks = qsc_pkg::STOP_15;
		end else begin
			stop_ticks = qsc_pkg::STOP_2;
		end
	end

	// Serial output level, break forcing and loopback routing
	always_comb begin
		unique case (s_q.txs)
			qsc_pkg::TX_START: tx_line = 1'b0;
			qsc_pkg::TX_DATA: begin
				if (s_q.tx_bit == nbits) begin
					tx_line = s_q.lctl[qsc_pkg::LC_EPS] ? s_q.tx_par : !s_q.tx_par;
				end else begin
					tx_line = s_q.tx_sh[0];
				end
			end
			qsc_pkg::TX_IDLE, qsc_pkg::TX_STOP: tx_line = 1'b1;
		endcase
		tx_wire = tx_line && !s_q.lctl[qsc_pkg::LC_BREAK];
		rin = loop ? tx_wire : sin_i;
	end

	// Interrupt identification by fixed priority
	always_comb begin
		if (s_q.ien[qsc_pkg::IE_LS] && (s_q.err != 4'h0)) begin
			iid = qsc_pkg::IID_LS;
		end else if (s_q.ien[qsc_pkg::IE_RXD] && (s_q.fifo_en ? rx_at_trig : rx_valid)) begin
			iid = qsc_pkg::IID_RX;
		end else if (s_q.ien[qsc_pkg::IE_THRE] && s_q.thre_pend) begin
			iid = qsc_pkg::IID_THRE;
		end else if (s_q.ien[qsc_pkg::IE_MS] && s_q.dcts && !auto_flow) begin
			iid = qsc_pkg::IID_MS;
		end else begin
			iid = qsc_pkg::IID_NONE;
		end
	end

	// Next state: bus, divider, modem input, transmitter, receiver
	always_comb begin
		s_d = s_q;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		tx_clr = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		rx_clr = 1'b0;
		rx_new = '0;
		tick = 1'b0;
		tx_load = 1'b0;
		// One registered ack per request; read data and enable on the same edge
		s_d.ack = req && !s_q.ack;
		s_d.oe = 1'b0;
		s_d.rdata = 8'h00;
		if (acc && !wb_we_i) begin
			s_d.oe = 1'b1;
			case (register_select_i)
				qsc_pkg::REG_DATA: begin
					s_d.rdata = dlab ? s_q.div[7:0] : rx_head.data;
					rx_pop = !dlab;
				end
				qsc_pkg::REG_IEN: s_d.rdata = dlab ? s_q.div[15:8] : {4'h0, s_q.ien};
				qsc_pkg::REG_IID: begin
					s_d.rdata = {s_q.fifo_en, s_q.fifo_en, 2'b00, iid};
					if (iid == qsc_pkg::IID_THRE) begin
						s_d.thre_pend = 1'b0;
					end
				end
				qsc_pkg::REG_LCTL: s_d.rdata = s_q.lctl;
				qsc_pkg::REG_MCTL: s_d.rdata = {2'b00, s_q.mctl};
				qsc_pkg::REG_LSTAT: begin
					s_d.rdata[qsc_pkg::LS_DR] = rx_valid;
					s_d.rdata[qsc_pkg::LS_OE +: 4] = s_q.err;
					s_d.rdata[qsc_pkg::LS_THRE] = tx_empty;
					s_d.rdata[qsc_pkg::LS_TEMT] = temt;
					s_d.rdata[qsc_pkg::LS_RXERR] = rx_err_head;
					s_d.err = 4'h0;
				end
				qsc_pkg::REG_MSTAT: begin
					s_d.rdata[qsc_pkg::MS_CTS] = s_q.cts_s;
					s_d.rdata[qsc_pkg::MS_DCTS] = s_q.dcts;
					s_d.dcts = 1'b0;
				end
				default: s_d.rdata = s_q.scratch;
			endcase
		end
		if (acc && wb_we_i) begin
			case (register_select_i)
				qsc_pkg::REG_DATA: begin
					if (dlab) begin
						s_d.div[7:0] = host_data_bus_i;
					end else begin
						tx_push = 1'b1;
						s_d.thre_pend = 1'b0;
					end
				end
				qsc_pkg::REG_IEN: begin
					if (dlab) begin
						s_d.div[15:8] = host_data_bus_i;
					end else begin
						s_d.ien = host_data_bus_i[3:0];
						if (host_data_bus_i[qsc_pkg::IE_THRE] && tx_empty) begin
							s_d.thre_pend = 1'b1;
						end
					end
				end
				qsc_pkg::REG_IID: begin
					s_d.fifo_en = host_data_bus_i[qsc_pkg::FC_EN];
					s_d.dma_mode = host_data_bus_i[qsc_pkg::FC_DMA];
					s_d.trig = host_data_bus_i[qsc_pkg::FC_TRIG +: 2];
					rx_clr = host_data_bus_i[qsc_pkg::FC_RXCLR] || (host_data_bus_i[qsc_pkg::FC_EN] != s_q.fifo_en);
					tx_clr = host_data_bus_i[qsc_pkg::FC_TXCLR] || (host_data_bus_i[qsc_pkg::FC_EN] != s_q.fifo_en);
				end
				qsc_pkg::REG_LCTL: s_d.lctl = host_data_bus_i;
				qsc_pkg::REG_MCTL: s_d.mctl = host_data_bus_i[5:0];
				qsc_pkg::REG_LSTAT: s_d.err = s_q.err | host_data_bus_i[qsc_pkg::LS_OE +: 4];
				qsc_pkg::REG_MSTAT: s_d.dcts = s_q.dcts | host_data_bus_i[qsc_pkg::MS_DCTS];
				default: s_d.scratch = host_data_bus_i;
			endcase
		end
		// Baud divider; a zero divisor stops the tick
		if (s_q.div != 16'h0000) begin
			if (s_q.bcnt >= s_q.div - 16'h0001) begin
				s_d.bcnt = 16'h0000;
				tick = 1'b1;
			end else begin
				s_d.bcnt = s_q.bcnt + 16'h0001;
			end
		end
		// Clear-to-send through two flops, then change detection after the bus clear
		s_d.cts_m = loop ? s_q.mctl[qsc_pkg::MC_RTS] : !cts_n_i;
		s_d.cts_s = s_q.cts_m;
		s_d.cts_p = s_q.cts_s;
		if (s_q.cts_s != s_q.cts_p) begin
			s_d.dcts = 1'b1;
		end
		// Transmitter; frames start on a tick so every bit lasts sixteen whole ticks, and chain back to back
		if (tick) begin
			s_d.tx_tk = s_q.tx_tk + 6'h01;
			unique case (s_q.txs)
				qsc_pkg::TX_IDLE: tx_load = tx_go;
				qsc_pkg::TX_START: begin
					if (s_q.tx_tk == {2'b00, qsc_pkg::BIT_LAST}) begin
						s_d.tx_tk = 6'h00;
						s_d.tx_bit = 4'h0;
						s_d.txs = qsc_pkg::TX_DATA;
					end
				end
				qsc_pkg::TX_DATA: begin
					if (s_q.tx_tk == {2'b00, qsc_pkg::BIT_LAST}) begin
						s_d.tx_tk = 6'h00;
						s_d.tx_bit = s_q.tx_bit + 4'h1;
						if (s_q.tx_bit < nbits) begin
							s_d.tx_sh = s_q.tx_sh >> 1;
							s_d.tx_par = s_q.tx_par ^ s_q.tx_sh[0];
						end
						if (tx_last) begin
							s_d.txs = qsc_pkg::TX_STOP;
						end
					end
				end
				qsc_pkg::TX_STOP: begin
					// At or past the end, so a format change during the stop bit cannot hang it
					if (s_q.tx_tk >= stop_ticks - 6'h01) begin
						s_d.txs = qsc_pkg::TX_IDLE;
						tx_load = tx_go;
					end
				end
			endcase
		end
		// Load the next character; the buffer running empty raises the empty pending flag
		if (tx_load) begin
			tx_pop = 1'b1;
			s_d.tx_sh = tx_head;
			s_d.tx_par = 1'b0;
			s_d.tx_tk = 6'h00;
			s_d.txs = qsc_pkg::TX_START;
			if (tx_cnt == CW'(1) && !tx_push) begin
				s_d.thre_pend = 1'b1;
			end
		end
		// Receiver
		if (tick) begin
			s_d.rx_tk = s_q.rx_tk + 4'h1;
			unique case (s_q.rxs)
				qsc_pkg::RX_IDLE: begin
					s_d.rx_tk = 4'h0;
					if (!rin) begin
						s_d.rxs = qsc_pkg::RX_START;
					end
				end
				qsc_pkg::RX_START: begin
					if (s_q.rx_tk == qsc_pkg::MID_SAMPLE) begin
						s_d.rx_tk = 4'h0;
						s_d.rx_bit = 4'h0;
						s_d.rx_par = 1'b0;
						s_d.rx_pe = 1'b0;
						s_d.rx_one = 1'b0;
						s_d.rxs = rin ? qsc_pkg::RX_IDLE : qsc_pkg::RX_DATA;
					end
				end
				qsc_pkg::RX_DATA: begin
					if (s_q.rx_tk == qsc_pkg::BIT_LAST) begin
						s_d.rx_bit = s_q.rx_bit + 4'h1;
						s_d.rx_one = s_q.rx_one | rin;
						if (s_q.rx_bit < nbits) begin
							s_d.rx_sh = {rin, s_q.rx_sh[7:1]};
							s_d.rx_par = s_q.rx_par ^ rin;
						end else begin
							s_d.rx_pe = rin != (s_q.lctl[qsc_pkg::LC_EPS] ? s_q.rx_par : !s_q.rx_par);
						end
						if (rx_last) begin
							s_d.rxs = qsc_pkg::RX_STOP;
						end
					end
				end
				qsc_pkg::RX_STOP: begin
					if (s_q.rx_tk == qsc_pkg::BIT_LAST) begin
						rx_push = 1'b1;
						rx_new.data = 8'(s_q.rx_sh >> (3'h3 - {1'b0, s_q.lctl[qsc_pkg::LC_WLEN +: 2]}));
						rx_new.pe = s_q.rx_pe;
						rx_new.fe = !rin;
						rx_new.bi = !rin && !s_q.rx_one;
						s_d.err = s_d.err | {rx_new.bi, rx_new.fe, rx_new.pe, !rx_ready};
						s_d.rxs = rx_new.bi ? qsc_pkg::RX_BREAK : qsc_pkg::RX_IDLE;
					end
				end
				qsc_pkg::RX_BREAK: begin
					if (rin) begin
						s_d.rxs = qsc_pkg::RX_IDLE;
					end
				end
				default: s_d.rxs = qsc_pkg::RX_IDLE;
			endcase
		end
	end

	// Transmit buffer: sixteen deep, or one holding register without fifo mode
	qsc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.clr_i(tx_clr),
		.one_i(!s_q.fifo_en),
		.push_valid_i(tx_push),
		.push_data_i(host_data_bus_i),
		.push_ready_o(tx_ready),
		.pop_valid_o(tx_valid),
		.pop_data_o(tx_head),
		.pop_ready_i(tx_pop),
		.count_o(tx_cnt)
	);

	// Receive buffer with per-character error bits
	qsc_fifo #(.W($bits(qsc_pkg::qsc_rx_entry_s)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.clr_i(rx_clr),
		.one_i(!s_q.fifo_en),
		.push_valid_i(rx_push),
		.push_data_i(rx_new),
		.push_ready_o(rx_ready),
		.pop_valid_o(rx_valid),
		.pop_data_o(rx_head),
		.pop_ready_i(rx_pop),
		.count_o(rx_cnt)
	);

	// State register; all control clears to zero on reset
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign wb_ack_o = s_q.ack;
	assign host_data_bus_o = s_q.rdata;
	assign host_data_bus_oe_o = s_q.oe;
	assign sout_o = loop ? 1'b1 : tx_wire;
	assign dtr_n_o = loop ? 1'b1 : !s_q.mctl[qsc_pkg::MC_DTR];
	assign rts_n_o = loop ? 1'b1 : !(s_q.mctl[qsc_pkg::MC_RTS] && !(auto_flow && rx_at_trig));
	assign channel_interrupt_out_o = (iid != qsc_pkg::IID_NONE);
	assign dma_o.rx_req_n = !(s_q.dma_mode ? rx_at_trig : rx_valid);
	assign dma_o.tx_req_n = !(s_q.dma_mode ? tx_ready : tx_empty);
endmodule

// ---- rtl/qsc_fifo.sv ----
// Synchronous fifo with single-entry mode, used for both serial directions
`timescale 1ns/1ns
module qsc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Control
	input wire logic clr_i,
	input wire logic one_i,
	// Fill side
	input wire logic push_valid_i,
	input wire logic [W-1:0] push_data_i,
	output logic push_ready_o,
	// Drain side
	output logic pop_valid_o,
	output logic [W-1:0] pop_data_o,
	input wire logic pop_ready_i,
	output logic [AW:0] count_o
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} qsc_fifo_s;

	qsc_fifo_s s_q;
	qsc_fifo_s s_d;
	logic do_push;
	logic do_pop;

	// Single-entry mode behaves as one holding register; a slot freed by a pop this cycle takes the push
	assign push_ready_o = do_pop || (one_i ? (s_q.cnt == '0) : (s_q.cnt != (AW + 1)'(DEPTH)));
	assign pop_valid_o = (s_q.cnt != '0);
	assign pop_data_o = s_q.mem[s_q.rd];
	assign count_o = s_q.cnt;
	assign do_push = push_valid_i && push_ready_o;
	assign do_pop = pop_ready_i && pop_valid_o;

	// Pointer and count update; clear wins over traffic
	always_comb begin
		s_d = s_q;
		if (do_push) begin
			s_d.mem[s_q.wr] = push_data_i;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (do_pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
		if (clr_i) begin
			s_d.wr = '0;
			s_d.rd = '0;
			s_d.cnt = '0;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ---- shared/qsc_pkg.sv ----
// Register map, field positions, reset values, timing and types of the serial channel
package qsc_pkg;
	// Register indices on the 3-bit register select
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_IEN = 3'h1;
	localparam logic [2:0] REG_IID = 3'h2;
	localparam logic [2:0] REG_LCTL = 3'h3;
	localparam logic [2:0] REG_MCTL = 3'h4;
	localparam logic [2:0] REG_LSTAT = 3'h5;
	localparam logic [2:0] REG_MSTAT = 3'h6;
	localparam logic [2:0] REG_SCRATCH = 3'h7;
	// Interrupt enable fields
	localparam int IE_RXD = 0;
	localparam int IE_THRE = 1;
	localparam int IE_LS = 2;
	localparam int IE_MS = 3;
	// Fifo control fields
	localparam int FC_EN = 0;
	localparam int FC_RXCLR = 1;
	localparam int FC_TXCLR = 2;
	localparam int FC_DMA = 3;
	localparam int FC_TRIG = 6;
	// Line control fields
	localparam int LC_WLEN = 0;
	localparam int LC_STOP = 2;
	localparam int LC_PEN = 3;
	localparam int LC_EPS = 4;
	localparam int LC_BREAK = 6;
	localparam int LC_DLAB = 7;
	// Modem control fields
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_LOOP = 4;
	localparam int MC_AFE = 5;
	// Line status fields; error flags OE, PE, FE, BI sit at LS_OE upward
	localparam int LS_DR = 0;
	localparam int LS_OE = 1;
	localparam int LS_THRE = 5;
	localparam int LS_TEMT = 6;
	localparam int LS_RXERR = 7;
	// Modem status fields
	localparam int MS_DCTS = 0;
	localparam int MS_CTS = 4;
	// Interrupt identity codes
	localparam logic [3:0] IID_NONE = 4'h1;
	localparam logic [3:0] IID_LS = 4'h6;
	localparam logic [3:0] IID_RX = 4'h4;
	localparam logic [3:0] IID_THRE = 4'h2;
	localparam logic [3:0] IID_MS = 4'h0;
	// Reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0000;
	// Fifo depth, then timing in 16x ticks
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] BIT_LAST = 4'hf;
	localparam logic [3:0] MID_SAMPLE = 4'h7;
	localparam logic [5:0] STOP_1 = 6'h10;
	localparam logic [5:0] STOP_15 = 6'h18;
	localparam logic [5:0] STOP_2 = 6'h20;
	// Receive trigger levels, indexed by the trigger field
	localparam logic [3:0][7:0] RX_TRIG = {8'h0e, 8'h08, 8'h04, 8'h01};
	// State codes
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11} qsc_tx_e;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_STOP = 3'b011,
		RX_BREAK = 3'b100
	} qsc_rx_e;
	// Receive entry: character plus its three error bits
	typedef struct packed {
		logic bi;
		logic fe;
		logic pe;
		logic [7:0] data;
	} qsc_rx_entry_s;
	// DMA request pair, active low
	typedef struct packed {
		logic rx_req_n;
		logic tx_req_n;
	} qsc_dma_s;
endpackage

// ---- tb/qsc_channel_properties.sv ----
// Port-level checker of the serial channel, bound to its top module
`timescale 1ns/1ns
module qsc_channel_properties (
	// Clock, reset and register port
	input wire logic ref_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, channel_select_n_i,
	input wire logic [2:0] register_select_i,
	input wire logic [7:0] host_data_bus_i, host_data_bus_o,
	input wire logic host_data_bus_oe_o, wb_ack_o,
	// Line, modem, interrupt and DMA
	input wire logic sin_i, cts_n_i, sout_o, rts_n_o, dtr_n_o, channel_interrupt_out_o,
	input wire qsc_pkg::qsc_dma_s dma_o
);
	logic [7:0] ien_q, lctl_q, mctl_q;
	logic req, wsel;
	// A request is taken while ack is low
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wsel = req && wb_we_i && !channel_select_n_i;
	// Shadow copies of the control registers
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ien_q <= 8'h00;
			lctl_q <= 8'h00;
			mctl_q <= 8'h00;
		end else if (wsel) begin
			if (register_select_i == qsc_pkg::REG_LCTL) lctl_q <= host_data_bus_i;
			if (register_select_i == qsc_pkg::REG_MCTL) mctl_q <= host_data_bus_i;
			if (register_select_i == qsc_pkg::REG_IEN && !lctl_q[qsc_pkg::LC_DLAB]) ien_q <= host_data_bus_i;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_ack_follows: assert property (req |=> wb_ack_o) else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_oe_reads_only: assert property (host_data_bus_oe_o |-> wb_ack_o && !$past(wb_we_i)
		&& !$past(channel_select_n_i)) else $error("bus driven outside a read");
	a_read_drives: assert property (req && !wb_we_i && !channel_select_n_i |=> host_data_bus_oe_o)
		else $error("read not driven");
	a_unsel_quiet: assert property (req && channel_select_n_i |=> !host_data_bus_oe_o && host_data_bus_o == 8'h00)
		else $error("unselected access answered");
	a_bus_idle: assert property (!wb_ack_o |-> host_data_bus_o == 8'h00) else $error("data out of ack");
	a_loop_quiet: assert property (mctl_q[qsc_pkg::MC_LOOP] && $past(mctl_q[qsc_pkg::MC_LOOP])
		|-> sout_o && rts_n_o && dtr_n_o) else $error("pins active in loopback");
	a_break_low: assert property (lctl_q[qsc_pkg::LC_BREAK] && $past(lctl_q[qsc_pkg::LC_BREAK])
		&& !mctl_q[qsc_pkg::MC_LOOP] |-> !sout_o) else $error("break not driven");
	a_irq_masked: assert property (ien_q[3:0] == 4'h0 && $past(ien_q[3:0]) == 4'h0
		|-> !channel_interrupt_out_o) else $error("interrupt while disabled");
	a_cts_irq: assert property ($changed(cts_n_i) && ien_q[qsc_pkg::IE_MS] && !mctl_q[qsc_pkg::MC_AFE]
		&& !mctl_q[qsc_pkg::MC_LOOP] |-> ##[1:5] channel_interrupt_out_o) else $error("no modem interrupt");
endmodule
bind qsc_channel qsc_channel_properties chk (.*);

// ---- tb/qsc_channel_test.sv ----
// Self-checking bench of the serial channel through its register port
`timescale 1ns/1ns
module qsc_channel_test;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, csn = 1'b1;
	logic cts_n = 1'b1, send = 1'b0, fls = 1'b0, roe, oe, ack, sin, sout, rts_n, dtr_n, irq, busy;
	logic [2:0] adr = 3'h0;
	logic [7:0] wdat = 8'h00, tdat = 8'h00, rdat, dq;
	logic [15:0] mon;
	qsc_pkg::qsc_dma_s dma;
	int error_cnt = 0, cmp_count = 0, nb = 10, dv = 1;
	time t_fall[$];
	// Frame cases: divisor, line control, character
	logic [7:0] tbl [6][3] = '{'{8'h01, 8'h03, 8'h55}, '{8'h01, 8'h1b, 8'ha7}, '{8'h01, 8'h0e, 8'h3c},
		'{8'h01, 8'h04, 8'h15}, '{8'h02, 8'h19, 8'h2d}, '{8'h03, 8'h03, 8'h81}};
	// Clock
	always #5 clk = ~clk;
	qsc_channel uut (.ref_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.channel_select_n_i(csn), .register_select_i(adr), .host_data_bus_i(wdat), .host_data_bus_o(dq),
		.host_data_bus_oe_o(oe), .wb_ack_o(ack), .sin_i(sin), .cts_n_i(cts_n), .sout_o(sout),
		.rts_n_o(rts_n), .dtr_n_o(dtr_n), .channel_interrupt_out_o(irq), .dma_o(dma));
	qsc_line_model #(.BIT_CYC(16)) modem (.ref_clk_i(clk), .send_i(send), .false_i(fls), .data_i(tdat),
		.sin_o(sin), .busy_o(busy));
	task summarize;
		if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// One classic cycle; answer taken at the rising edge where ack is sampled high
	task automatic bus(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
		int n;
		n = 0;
		{cyc, stb, we, csn, adr, wdat} <= {2'b11, w, c, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			summarize();
		end
		{roe, rdat} = {oe, dq};
		{cyc, stb, csn} <= 3'b001;
		@(posedge clk);
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task rd(input logic c, input logic [2:0] a, input logic [8:0] e);
		bus(1'b0, c, a, 8'h00);
		chk($sformatf("reg %0d", a), {roe, rdat}, e);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return sout;
			1: return dma.rx_req_n;
			2: return busy;
			default: return t_fall.size() > 1;
		endcase
	endfunction
	task automatic waitfor(input int s, input logic v);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (pick(s) !== v && n < 9000);
		if (n >= 9000) begin
			error_cnt++;
			summarize();
		end
		@(posedge clk);
	endtask
	task sendc(input logic [7:0] c);
		tdat <= c;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		waitfor(2, 1'b0);
	endtask
	// Two back-to-back frames: bits at mid-bit and start-to-start spacing
	task automatic txf(input logic [7:0] d, input logic [7:0] l, input logic [7:0] c);
		int wl;
		logic [15:0] e;
		wl = l[1:0] + 5;
		nb = wl + l[3] + 2;
		dv = d;
		e = 16'h0000;
		for (int i = 0; i < wl; i++) e[i + 1] = c[i];
		e[wl + 1] = l[3] ? (^e ^ !l[4]) : 1'b1;
		e[nb - 1] = 1'b1;
		wr(3'h3, 8'h80);
		wr(3'h0, d);
		wr(3'h1, 8'h00);
		wr(3'h3, l);
		t_fall.delete();
		wr(3'h0, c);
		wr(3'h0, c);
		waitfor(3, 1'b1);
		repeat (16 * dv * nb) @(posedge clk);
		chk("frame", mon & ((16'h1 << nb) - 16'h1), e);
		chk("gap", 16'(t_fall[1] - t_fall[0]), 16'(160 * dv * (nb - 1) + 10 * dv
			* (!l[2] ? 16 : (l[1:0] == 2'b00 ? 24 : 32))));
	endtask
	// Line monitor
	always begin
		@(negedge sout);
		t_fall.push_back($time);
		repeat (8 * dv) @(negedge clk);
		for (int k = 0; k < nb; k++) begin
			if (k > 0) repeat (16 * dv) @(negedge clk);
			mon[k] = sout;
		end
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pins", {sout, rts_n, dtr_n, irq, dma}, 16'h003a);
		rd(0, 3'h5, 9'h160);
		rd(0, 3'h2, 9'h101);
		wr(3'h7, 8'ha5);
		bus(1'b1, 1'b1, 3'h7, 8'h5a);
		rd(1, 3'h7, 9'h000);
		rd(0, 3'h7, 9'h1a5);
		for (int i = 0; i < 6; i++) txf(tbl[i][0], tbl[i][1], tbl[i][2]);
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h01);
		wr(3'h3, 8'h03);
		wr(3'h4, 8'h13);
		wr(3'h0, 8'h9e);
		chk("loop pins", {sout, rts_n, dtr_n}, 16'h0007);
		waitfor(1, 1'b0);
		rd(0, 3'h0, 9'h19e);
		wr(3'h4, 8'h00);
		sendc(8'hc3);
		waitfor(1, 1'b0);
		rd(0, 3'h5, 9'h161);
		rd(0, 3'h0, 9'h1c3);
		fls <= 1'b1;
		@(posedge clk);
		fls <= 1'b0;
		repeat (200) @(posedge clk);
		chk("rx req", dma.rx_req_n, 1'b1);
		sendc(8'h11);
		sendc(8'h22);
		rd(0, 3'h5, 9'h163);
		rd(0, 3'h5, 9'h161);
		bus(1'b0, 1'b0, 3'h0, 8'h00);
		wr(3'h1, 8'h06);
		wr(3'h5, 8'h1e);
		chk("irq", irq, 1'b1);
		rd(0, 3'h2, 9'h106);
		rd(0, 3'h5, 9'h17e);
		rd(0, 3'h2, 9'h102);
		rd(0, 3'h2, 9'h101);
		chk("irq", irq, 1'b0);
		rd(0, 3'h6, 9'h101);
		wr(3'h1, 8'h08);
		chk("irq", irq, 1'b0);
		cts_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("irq", irq, 1'b1);
		rd(0, 3'h6, 9'h111);
		rd(0, 3'h6, 9'h110);
		chk("irq", irq, 1'b0);
		wr(3'h2, 8'h01);
		wr(3'h4, 8'h22);
		cts_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("irq", irq, 1'b0);
		rd(0, 3'h6, 9'h101);
		wr(3'h0, 8'h5a);
		repeat (100) @(posedge clk);
		chk("gated", {sout, rts_n}, 16'h0002);
		cts_n <= 1'b0;
		waitfor(0, 1'b0);
		sendc(8'h3c);
		waitfor(1, 1'b0);
		chk("rts", rts_n, 1'b1);
		rd(0, 3'h0, 9'h13c);
		chk("rts", rts_n, 1'b0);
		wr(3'h3, 8'h43);
		chk("break", sout, 1'b0);
		wr(3'h3, 8'h03);
		summarize();
	end
	// Watchdog
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		summarize();
	end
endmodule

// ---- tb/qsc_line_model.sv ----
// Far end of the serial line: sends 8N1 characters and false start pulses
`timescale 1ns/1ns
module qsc_line_model #(
	parameter int BIT_CYC = 16
) (
	// Clock and commands
	input wire logic ref_clk_i,
	input wire logic send_i,
	input wire logic false_i,
	input wire logic [7:0] data_i,
	// Line and status
	output logic sin_o,
	output logic busy_o
);
	logic [9:0] frm;
	// Line idles high between frames
	initial begin
		sin_o = 1'b1;
		busy_o = 1'b0;
		forever begin
			@(posedge ref_clk_i);
			if (send_i) begin
				busy_o <= 1'b1;
				frm = {1'b1, data_i, 1'b0};
				// Start, data LSB first, one stop bit
				for (int i = 0; i < 10; i++) begin
					sin_o <= frm[i];
					repeat (BIT_CYC) @(posedge ref_clk_i);
				end
				busy_o <= 1'b0;
			end else if (false_i) begin
				sin_o <= 1'b0; // Low pulse gone before mid start
				repeat (BIT_CYC / 4) @(posedge ref_clk_i);
				sin_o <= 1'b1;
			end
		end
	end
endmodule
